// ==== shared/angle_cfg_pkg.sv ====
// package: register indices, field positions, reset values and carriers
package angle_cfg_pkg;
   // ------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------
   localparam logic [4:0] REG_ZERO_LO = 5'h00;
   localparam logic [4:0] REG_ZERO_HI = 5'h01;
   localparam logic [4:0] REG_TRIM = 5'h02;
   localparam logic [4:0] REG_TRIM_EN = 5'h03;
   localparam logic [4:0] REG_FIELD = 5'h06;
   localparam logic [4:0] REG_CHANGE = 5'h07;
   localparam logic [4:0] REG_THRESH = 5'h08;
   localparam logic [4:0] REG_DIR = 5'h09;
   localparam logic [4:0] REG_REF = 5'h0a;
   localparam logic [4:0] REG_FILTER = 5'h0e;
   localparam logic [4:0] REG_ANGLE_LO = 5'h1c;
   localparam logic [4:0] REG_ANGLE_HI = 5'h1d;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int POS_TRIM_X = 0;
   localparam int POS_TRIM_Y = 1;
   localparam int POS_FIELD_EN = 0;
   localparam int POS_FIELD_HIGH = 2;
   localparam int POS_FIELD_LOW = 5;
   localparam int POS_CHANGE_HYSTERESIS = 0;
   localparam int POS_REF_AUTO = 6;
   localparam int POS_STYLE = 7;
   localparam int POS_DIR = 7;
   localparam int POS_FILTER = 4;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [7:0] RST_TRIM = 8'h00;
   localparam logic [7:0] RST_TRIM_EN = 8'h00;
   localparam logic [7:0] RST_FIELD = 8'h1d;
   localparam logic [7:0] RST_CHANGE = 8'h83;
   localparam logic [7:0] RST_THRESH = 8'h40;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_REF = 8'h40;
   localparam logic [7:0] RST_FILTER = 8'ha0;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] bias_trim_amount;
      logic trim_x_enable;
      logic trim_y_enable;
      logic field_check_enable;
      logic [2:0] field_high_level;
      logic [2:0] field_low_level;
      logic change_flag_style;
      logic ref_auto_update;
      logic [5:0] change_hysteresis;
      logic [7:0] change_threshold;
      logic [7:0] change_reference;
      logic [3:0] filter_window_size;
   } cfg_s;
   typedef struct packed {
      logic [7:0] x_amount;
      logic [7:0] y_amount;
   } trim_s;
endpackage

// ==== hw/angle_post.sv ====
// angle post-processing: zero offset and rotation sense
`timescale 1ns/10ps
module angle_post #(
   parameter int WIDTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] raw_angle,
   input wire logic [WIDTH-1:0] zero_offset,
   input wire logic ccw_positive,
   output logic [WIDTH-1:0] out_angle
);
   wire logic [WIDTH-1:0] sensed;
   wire logic [WIDTH-1:0] diff;
   // mirror the raw angle for counterclockwise sense
   assign sensed = ccw_positive ? WIDTH'(-raw_angle) : raw_angle;
   // subtraction wraps modulo one turn
   assign diff = WIDTH'(sensed - zero_offset);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_angle <= '0;
      end else begin
         out_angle <= diff;
      end
   end
endmodule

// ==== hw/angle_cfg.sv ====
// configuration register set and angle output for the angle sensor core
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module angle_cfg
   import angle_cfg_pkg::*;
#(
   parameter int AW = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic [AW-1:0] raw_angle,
   input wire logic change_event,
   input wire logic [7:0] change_new_ref,
   output logic [AW-1:0] out_angle,
   output angle_cfg_pkg::cfg_s cfg,
   output angle_cfg_pkg::trim_s trim
);
   import angle_cfg_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0] zero_r;
   logic [7:0] trim_r;
   logic [1:0] trim_en_r;
   logic [7:0] field_r;
   logic [7:0] change_r;
   logic [7:0] thresh_r;
   logic dir_r;
   logic [7:0] ref_r;
   logic [3:0] filter_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [7:0] axis_amt_r [2];

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire logic wr_zlo = wr_stb && addr == REG_ZERO_LO;
   wire logic wr_zhi = wr_stb && addr == REG_ZERO_HI;
   wire logic wr_trim = wr_stb && addr == REG_TRIM;
   wire logic wr_trim_en = wr_stb && addr == REG_TRIM_EN;
   wire logic wr_field = wr_stb && addr == REG_FIELD;
   wire logic wr_change = wr_stb && addr == REG_CHANGE;
   wire logic wr_thresh = wr_stb && addr == REG_THRESH;
   wire logic wr_dir = wr_stb && addr == REG_DIR;
   wire logic wr_ref = wr_stb && addr == REG_REF;
   wire logic wr_filter = wr_stb && addr == REG_FILTER;
   wire logic [7:0] field_word = {wdata[POS_FIELD_LOW+:3], wdata[POS_FIELD_HIGH+:3], 1'b0,
      wdata[POS_FIELD_EN]};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         zero_r <= RST_ZERO;
      end else begin
         if (wr_zlo) zero_r[7:0] <= wdata;
         if (wr_zhi) zero_r[15:8] <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trim_r <= RST_TRIM;
      end else if (wr_trim) begin
         trim_r <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trim_en_r <= RST_TRIM_EN[1:0];
      end else if (wr_trim_en) begin
         trim_en_r <= wdata[1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         field_r <= RST_FIELD;
      end else if (wr_field) begin
         field_r <= field_word;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         change_r <= RST_CHANGE;
      end else if (wr_change) begin
         change_r <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         thresh_r <= RST_THRESH;
      end else if (wr_thresh) begin
         thresh_r <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dir_r <= RST_DIR[POS_DIR];
      end else if (wr_dir) begin
         dir_r <= wdata[POS_DIR];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         filter_r <= RST_FILTER[POS_FILTER+:4];
      end else if (wr_filter) begin
         filter_r <= wdata[POS_FILTER+:4];
      end
   end

   // ------------------------------------------------------------
   // reference: hardware update wins over software write
   // ------------------------------------------------------------
   wire logic ref_auto = change_r[POS_REF_AUTO];
   wire logic ref_load = ref_auto && change_event;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ref_r <= RST_REF;
      end else if (ref_load) begin
         ref_r <= change_new_ref;
      end else if (wr_ref) begin
         ref_r <= wdata;
      end
   end

   // ------------------------------------------------------------
   // trim steering
   // ------------------------------------------------------------
   generate
      for (genvar i = 0; i < 2; i++) begin : g_axis
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               axis_amt_r[i] <= 8'h00;
            end else begin
               axis_amt_r[i] <= trim_en_r[i] ? trim_r : 8'h00;
            end
         end
      end
   endgenerate
   assign trim.x_amount = axis_amt_r[POS_TRIM_X];
   assign trim.y_amount = axis_amt_r[POS_TRIM_Y];

   // ------------------------------------------------------------
   // configuration out
   // ------------------------------------------------------------
   assign cfg.bias_trim_amount = trim_r;
   assign cfg.trim_x_enable = trim_en_r[POS_TRIM_X];
   assign cfg.trim_y_enable = trim_en_r[POS_TRIM_Y];
   assign cfg.field_check_enable = field_r[POS_FIELD_EN];
   assign cfg.field_high_level = field_r[POS_FIELD_HIGH+:3];
   assign cfg.field_low_level = field_r[POS_FIELD_LOW+:3];
   assign cfg.change_flag_style = change_r[POS_STYLE];
   assign cfg.ref_auto_update = ref_auto;
   assign cfg.change_hysteresis = change_r[POS_CHANGE_HYSTERESIS+:6];
   assign cfg.change_threshold = thresh_r;
   assign cfg.change_reference = ref_r;
   assign cfg.filter_window_size = filter_r;

   // ------------------------------------------------------------
   // angle path
   // ------------------------------------------------------------
   angle_post #(.WIDTH(AW)) u_post (
      .ref_clk(ref_clk),
      .rst(rst),
      .raw_angle(raw_angle),
      .zero_offset(AW'(zero_r)),
      .ccw_positive(dir_r),
      .out_angle(out_angle)
   );

   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   wire logic [15:0] ang16 = 16'(out_angle);

   always_comb begin
      unique case (addr)
         REG_ZERO_LO: rdata_nxt = zero_r[7:0];
         REG_ZERO_HI: rdata_nxt = zero_r[15:8];
         REG_TRIM: rdata_nxt = trim_r;
         REG_TRIM_EN: rdata_nxt = {6'h00, trim_en_r};
         REG_FIELD: rdata_nxt = field_r;
         REG_CHANGE: rdata_nxt = change_r;
         REG_THRESH: rdata_nxt = thresh_r;
         REG_DIR: rdata_nxt = {dir_r, 7'h00};
         REG_REF: rdata_nxt = ref_r;
         REG_FILTER: rdata_nxt = {filter_r, 4'h0};
         REG_ANGLE_LO: rdata_nxt = ang16[7:0];
         REG_ANGLE_HI: rdata_nxt = ang16[15:8];
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rd_stb ? rdata_nxt : 8'h00;
      end
   end
   assign rdata = rdata_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_out_of_reset;
      !$past(rst);
   endsequence

   sequence s_pos_hold;
      !dir_r [*2] ##0 !$past(rst);
   endsequence

   sequence s_thresh_read;
      rd_stb && addr == REG_THRESH;
   endsequence

   a_zero_subtract: assert property (s_pos_hold |->
      out_angle == AW'($past(raw_angle) - $past(zero_r)))
      else $error("output angle not raw minus zero offset");
   a_zero_wrap: assert property (s_pos_hold ##0 ($past(raw_angle) < $past(zero_r)) |->
      out_angle == AW'({1'b1, $past(raw_angle)} - $past(zero_r)))
      else $error("offset subtraction did not wrap");
   a_sense_ccw: assert property (s_out_of_reset ##0 (dir_r && $past(dir_r)) |->
      out_angle == AW'(-$past(raw_angle) - $past(zero_r)))
      else $error("counterclockwise sense not applied");
   a_trim_x_gate: assert property (s_out_of_reset ##0 !$past(trim_en_r[POS_TRIM_X]) |->
      trim.x_amount == 8'h00)
      else $error("x trim applied while disabled");
   a_trim_both: assert property (s_out_of_reset ##0 ($past(trim_en_r) == 2'b11) |->
      trim.x_amount == trim.y_amount && trim.y_amount == $past(trim_r))
      else $error("both-axis trim not equal");
   a_dir_write: assert property (wr_dir |=> dir_r == $past(wdata[POS_DIR]))
      else $error("rotation sense write lost");
   a_ref_auto: assert property (ref_load |=> ref_r == $past(change_new_ref))
      else $error("reference not auto updated");
   a_ref_fixed: assert property (!ref_auto && !wr_ref |=> $stable(ref_r))
      else $error("fixed reference changed");
   a_thresh_write: assert property (wr_thresh |=> cfg.change_threshold == $past(wdata))
      else $error("threshold write lost");
   a_field_write: assert property (wr_field |=>
      cfg.field_low_level == $past(wdata[7:5]) && cfg.field_check_enable == $past(wdata[0]))
      else $error("field config write lost");

   // ------------------------------------------------------------
   // register writes and y trim gate
   // ------------------------------------------------------------
   a_field_high: assert property (wr_field |=>
      cfg.field_high_level == $past(wdata[POS_FIELD_HIGH+:3]))
      else $error("field high level write lost");
   a_trim_y_gate: assert property (s_out_of_reset ##0
      !$past(trim_en_r[POS_TRIM_Y]) |-> trim.y_amount == 8'h00)
      else $error("y trim applied while disabled");
   a_zero_write: assert property (wr_zlo |=> zero_r[7:0] == $past(wdata))
      else $error("zero offset low byte write lost");
   a_zero_high: assert property (wr_zhi |=> zero_r[15:8] == $past(wdata))
      else $error("zero offset high byte write lost");
   a_trim_write: assert property (wr_trim |=> cfg.bias_trim_amount == $past(wdata))
      else $error("trim amount write lost");
   a_trim_en_write: assert property (wr_trim_en |=>
      cfg.trim_x_enable == $past(wdata[POS_TRIM_X]) && cfg.trim_y_enable == $past(wdata[POS_TRIM_Y]))
      else $error("trim enable write lost");
   a_change_write: assert property (wr_change |=>
      cfg.change_hysteresis == $past(wdata[POS_CHANGE_HYSTERESIS+:6]) &&
      cfg.change_flag_style == $past(wdata[POS_STYLE]))
      else $error("change config write lost");
   a_filter_write: assert property (wr_filter |=>
      cfg.filter_window_size == $past(wdata[POS_FILTER+:4]))
      else $error("filter window write lost");

   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   a_read_thresh: assert property (s_thresh_read |=> rdata == $past(thresh_r))
      else $error("threshold read data wrong");
   a_read_idle: assert property (!rd_stb |=> rdata == 8'h00)
      else $error("read data not cleared after read");
endmodule

// ==== tb/cfg_host.sv ====
// register bus host model for the angle configuration block
`timescale 1ns/10ps
module cfg_host (
   input wire logic ref_clk,
   output logic [4:0] addr,
   output logic [7:0] wdata,
   output logic wr_stb,
   output logic rd_stb,
   input wire logic [7:0] rdata
);
   initial begin
      addr = 5'h1f;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   // side-shaft trim amount from field ratio, rounded
   function automatic logic [7:0] trim_amount(input real k);
      return 8'(int'(258.0 * (1.0 - 1.0 / k)));
   endfunction
   // released lines show the inverse of the last value
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      addr <= ~a;
      #1 d = rdata;
   endtask
   // rotation sense sits in the top bit of register 9
   task automatic set_sense(input logic ccw);
      wr(5'h09, {ccw, 7'h00});
   endtask
endmodule

// ==== tb/angle_cfg_bench.sv ====
// self-checking bench for the angle configuration block
`timescale 1ns/10ps
module angle_cfg_bench;
   import angle_cfg_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] rv;
   logic wr_stb;
   logic rd_stb;
   logic [15:0] raw_angle = 16'h0000;
   logic change_event = 1'b0;
   logic [7:0] change_new_ref = 8'h00;
   logic [15:0] out_angle;
   cfg_s cfg;
   trim_s trim;
   int mismatches = 0;
   int checked = 0;
   always #50 ref_clk = ~ref_clk;
   cfg_host host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata));
   angle_cfg #(.AW(16)) DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .raw_angle(raw_angle),
      .change_event(change_event), .change_new_ref(change_new_ref),
      .out_angle(out_angle), .cfg(cfg), .trim(trim));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic rchk(input logic [4:0] a, input logic [7:0] exp, input string m);
      host.rd(a, rv);
      chk(16'(rv), 16'(exp), m);
   endtask
   task automatic t_reset;
      logic [4:0] ra[11] = '{REG_ZERO_LO, REG_ZERO_HI, REG_TRIM, REG_TRIM_EN, REG_FIELD,
         REG_CHANGE, REG_THRESH, REG_DIR, REG_REF, REG_FILTER, 5'h05};
      logic [7:0] ev[11] = '{RST_ZERO[7:0], RST_ZERO[15:8], RST_TRIM, RST_TRIM_EN,
         RST_FIELD, RST_CHANGE, RST_THRESH, RST_DIR, RST_REF, RST_FILTER, 8'h00};
      for (int i = 0; i < 11; i++) begin
         rchk(ra[i], ev[i], "reset readback");
      end
      $display("reset test done");
   endtask
   task automatic t_fields;
      host.wr(REG_CHANGE, 8'hbf);
      host.wr(REG_THRESH, 8'hff);
      host.wr(REG_FILTER, 8'hf0);
      host.wr(REG_FIELD, 8'h01);
      @(posedge ref_clk);
      #1 chk(16'(cfg.change_flag_style), 16'h1, "style");
      chk(16'(cfg.ref_auto_update), 16'h0, "auto update");
      chk(16'(cfg.change_hysteresis), 16'h3f, "hysteresis");
      chk(16'(cfg.change_threshold), 16'hff, "threshold");
      chk(16'(cfg.filter_window_size), 16'hf, "filter");
      chk(16'(cfg.field_check_enable), 16'h1, "field check on");
      host.wr(REG_FIELD, 8'h00);
      @(posedge ref_clk);
      #1 chk(16'(cfg.field_check_enable), 16'h0, "field check off");
      chk(16'({cfg.field_high_level, cfg.field_low_level}), 16'h0, "levels");
      host.wr(REG_FIELD, 8'hbd);
      @(posedge ref_clk);
      #1 chk(16'(cfg.field_high_level), 16'h7, "high level");
      chk(16'(cfg.field_low_level), 16'h5, "low level");
      chk(16'(cfg.field_check_enable), 16'h1, "field check again");
      rchk(REG_FIELD, 8'hbd, "field readback");
      rchk(REG_THRESH, 8'hff, "threshold readback");
      $display("field test done");
   endtask
   task automatic pulse(input logic [7:0] v);
      @(posedge ref_clk);
      change_event <= 1'b1;
      change_new_ref <= v;
      @(posedge ref_clk);
      change_event <= 1'b0;
      change_new_ref <= ~v;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic t_ref;
      host.wr(REG_REF, 8'h22);
      rchk(REG_REF, 8'h22, "reference write");
      host.wr(REG_CHANGE, 8'h40);
      pulse(8'h5a);
      #1 chk(16'(cfg.change_reference), 16'h5a, "auto load");
      host.wr(REG_CHANGE, 8'h00);
      pulse(8'h11);
      #1 chk(16'(cfg.change_reference), 16'h5a, "fixed reference");
      $display("reference test done");
   endtask
   task automatic t_trim;
      logic [7:0] amt[2];
      amt[0] = host.trim_amount(2.0);
      amt[1] = 8'hff;
      chk(16'(amt[0]), 16'd129, "ratio two");
      foreach (amt[j]) begin
         host.wr(REG_TRIM, amt[j]);
         for (int e = 0; e < 4; e++) begin
            host.wr(REG_TRIM_EN, 8'(e));
            repeat (2) @(posedge ref_clk);
            #1 chk(16'(trim.x_amount), 16'(e[0] ? amt[j] : 8'h00), "x trim");
            chk(16'(trim.y_amount), 16'(e[1] ? amt[j] : 8'h00), "y trim");
            chk(16'({cfg.trim_y_enable, cfg.trim_x_enable}), 16'(e), "trim enables");
         end
         chk(16'(cfg.bias_trim_amount), 16'(amt[j]), "trim amount");
      end
      $display("trim test done");
   endtask
   task automatic ang(input logic [15:0] z, r, input logic ccw, input logic [15:0] exp);
      host.wr(REG_ZERO_LO, z[7:0]);
      host.wr(REG_ZERO_HI, z[15:8]);
      host.set_sense(ccw);
      @(posedge ref_clk);
      raw_angle <= r;
      repeat (3) @(posedge ref_clk);
      #1 chk(out_angle, exp, "angle");
      rchk(REG_ANGLE_LO, exp[7:0], "angle low");
      rchk(REG_ANGLE_HI, exp[15:8], "angle high");
   endtask
   task automatic t_angle;
      ang(16'h0000, 16'h1234, 1'b0, 16'h1234);
      ang(16'h0010, 16'h0005, 1'b0, 16'hfff5);
      ang(16'hffff, 16'h0000, 1'b0, 16'h0001);
      ang(16'h0010, 16'h0005, 1'b1, 16'hffeb);
      ang(16'h8000, 16'h4000, 1'b1, 16'h4000);
      ang(16'h0000, 16'h0000, 1'b1, 16'h0000);
      $display("angle test done");
   endtask
   task automatic t_rerun;
      host.wr(REG_TRIM_EN, 8'h03);
      host.wr(REG_THRESH, 8'h12);
      raw_angle <= 16'h0100;
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      #1 chk(out_angle, 16'h0000, "angle in reset");
      chk(16'({trim.x_amount, trim.y_amount}), 16'h0000, "trim in reset");
      chk(16'(cfg.change_threshold), 16'(RST_THRESH), "threshold reset");
      @(posedge ref_clk);
      #1 chk(out_angle, 16'h0100, "angle after reset");
      rchk(REG_TRIM_EN, RST_TRIM_EN, "trim enable reset");
      $display("reset rerun test done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      mismatches++;
      $display("watchdog expired");
      tally_and_finish;
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_fields;
      t_ref;
      t_trim;
      t_angle;
      t_rerun;
      tally_and_finish;
   end
endmodule
